// ===== pss_defs.vh
/*
 * Constants of the position segment sequencer: parameter indices, field
 * positions, encodings and reset values.
 * Assumes it is included by pss_sequencer.v; holds definitions only.
 */
`ifndef PSS_DEFS_VH
`define PSS_DEFS_VH

// Parameter indices; the APB byte address is four times the index.
`define PSS_CTRL_BASE    12'h804
`define PSS_PULSE_BASE   12'h806
`define PSS_TABLE_LAST   12'h87e
`define PSS_BANK_FIRST   12'h880
`define PSS_BANK_LAST    12'h897
`define PSS_CMD_REG      12'h8a0
`define PSS_STAT_REG     12'h8a1
`define PSS_SEG_STRIDE   4

// Control word fields: low half plans the path, high half picks bank entries.
`define PSS_F_MODE       3:0
`define PSS_F_TYPE       7:4
`define PSS_F_INTR       8
`define PSS_F_OVLP       12
`define PSS_F_ACC        18:16
`define PSS_F_DEC        22:20
`define PSS_F_SPD        26:24
`define PSS_F_DLY        30:28

// Bank entry groups: speeds start at entry 8, delays at entry 16.
`define PSS_SPD_GRP      2'b01
`define PSS_DLY_GRP      2'b10

// Segment modes and target types.
`define PSS_MODE_SINGLE  4'h0
`define PSS_MODE_MULTI   4'h1
`define PSS_MODE_SPEED   4'h2
`define PSS_MODE_JUMP    4'h3
`define PSS_TYPE_ABS     4'h0
`define PSS_TYPE_INC     4'h1
`define PSS_TYPE_REL     4'h2

// Command register fields.
`define PSS_CMD_NUM      4:0
`define PSS_CMD_TRIG     8
`define PSS_CMD_STOP     9

`define PSS_WORD_RESET   32'h00000000

`endif

// ===== pss_sequencer.v
/*
 * Position segment sequencer: segment table, parameter bank, APB slave and
 * the sequencing state machine that plans one segment at a time.
 * Assumes a trajectory planner on the same clock that reports completion,
 * speed reached and the remaining distance, and an asynchronous trigger pin.
 */
// Function
// - Control word of segment n sits at parameter index 0x804 plus 4n.
// - Pulse or speed value of segment n sits at index 0x806 plus 4n.
// - The table holds exactly 31 segments, control and value slot each.
// - Low 16 control bits set mode, overlap, target type and interrupt.
// - High 16 control bits pick speed, accel, decel and delay bank entries.
// - Mode 0 single, 1 multi, 2 speed, 3 jump.
// - Single mode stops after the segment completes.
// - Multi mode starts the next segment on completion, chaining runs.
// - Speed mode holds the speed until another segment starts.
// - Jump mode goes at once to the named segment and runs it.
// - Target type 0 absolute, 1 incremental, 2 relative.
// - Absolute target equals the segment value.
// - Relative target is feedback position plus segment value.
// - Incremental target is previous commanded target plus segment value.
// - Speed type 1 starts the next segment once speed is reached.
// - Interrupt bit set switches to the triggered segment at once.
// - An interrupting switch adds the unfinished remainder to the next target.
// - Interrupt bit clear waits for the current segment to complete.
// - Interrupt bit is judged at the later trigger, after configuration.
`timescale 1ns/1ps
`include "pss_defs.vh"

module pss_sequencer #(
  parameter NUM_SEG   = 31,
  parameter BANK_SIZE = 24
) (
  input  wire        clock_i,                  // 200 MHz system clock
  input  wire        rstn_i,                   // synchronous reset, active low
  input  wire        psel_i,                   // APB select
  input  wire        penable_i,                // APB enable
  input  wire        pwrite_i,                 // APB direction, high for write
  input  wire [13:0] paddr_i,                  // APB byte address
  input  wire [31:0] pwdata_i,                 // APB write data
  output reg  [31:0] prdata_o,                 // APB read data
  output wire        pready_o,                 // APB ready, always high
  output wire        pslverr_o,                // APB error on unmapped address
  input  wire [4:0]  segment_index_i,          // segment number pins
  input  wire        segment_trigger_input_i,  // rising edge starts segment
  input  wire [31:0] feedback_position_i,      // present feedback position
  input  wire        motion_done_i,            // planner finished the segment
  input  wire        speed_reached_i,          // planner reached target speed
  input  wire [31:0] remainder_i,              // distance still to go
  output reg         plan_strobe_o,            // pulse: new segment planned
  output reg  [1:0]  run_mode_o,               // mode of the planned segment
  output reg         overlap_o,                // overlap flag of the segment
  output reg  [31:0] target_position_o,        // planned target position
  output reg  [31:0] speed_value_o,            // planned speed
  output reg  [31:0] accel_time_o,             // selected acceleration time
  output reg  [31:0] decel_time_o,             // selected deceleration time
  output reg  [31:0] delay_time_o,             // selected delay time
  output reg         stop_o,                   // pulse: sequence stopped
  output wire        busy_o,                   // a segment is in progress
  output wire [4:0]  segment_number_o          // number of current segment
);

  localparam S_IDLE   = 2'd0;
  localparam S_FETCH  = 2'd1;
  localparam S_DECODE = 2'd2;
  localparam S_RUN    = 2'd3;

  // ******************************************************************
  // Storage
  // ******************************************************************
  reg [31:0] ctrl_mem  [0:NUM_SEG-1];
  reg [31:0] pulse_mem [0:NUM_SEG-1];
  reg [31:0] bank_mem  [0:BANK_SIZE-1];

  reg [1:0]  state;
  reg [4:0]  cur;
  reg [31:0] seg_ctrl;
  reg [31:0] seg_val;
  reg        nop_seg;
  reg        pend;
  reg [4:0]  pend_num;
  reg [31:0] carry;
  reg [31:0] cmd_target;
  reg [4:0]  idx_s1;
  reg [4:0]  idx_s2;
  reg        trig_s1;
  reg        trig_s2;
  reg        trig_s3;
  integer    i;

  // ******************************************************************
  // APB decode
  // ******************************************************************
  // Reserved indices between table slots answer with an error, so a software
  // slip into the gap is seen rather than silently stored.
  wire [11:0] idx      = paddr_i[13:2];
  wire [11:0] tab_off  = idx - `PSS_CTRL_BASE;
  wire [4:0]  tab_n    = tab_off[6:2];
  wire        in_tab   = (idx >= `PSS_CTRL_BASE) && (idx <= `PSS_TABLE_LAST);
  wire        is_ctrl  = in_tab && (tab_off[1:0] == 2'd0);
  wire        is_pulse = in_tab && (tab_off[1:0] == 2'd2);
  wire        in_bank  = (idx >= `PSS_BANK_FIRST) && (idx <= `PSS_BANK_LAST);
  wire [11:0] bank_off = idx - `PSS_BANK_FIRST;
  wire [4:0]  bank_n   = bank_off[4:0];
  wire        is_cmd   = (idx == `PSS_CMD_REG);
  wire        is_stat  = (idx == `PSS_STAT_REG);
  wire        hit      = is_ctrl || is_pulse || in_bank || is_cmd || is_stat;
  wire        wr_acc   = psel_i && penable_i && pwrite_i;
  wire        setup    = psel_i && !penable_i;

  // Zero wait states: read data is captured in the setup cycle.
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !hit;

  reg [31:0] next_rdata;
  always @* begin
    next_rdata = `PSS_WORD_RESET;
    if (is_ctrl)
      next_rdata = ctrl_mem[tab_n];
    else if (is_pulse)
      next_rdata = pulse_mem[tab_n];
    else if (in_bank)
      next_rdata = bank_mem[bank_n];
    else if (is_stat)
      next_rdata = {21'h0, (state == S_IDLE), pend, busy_o, 3'h0,
                    segment_number_o};
  end

  always @(posedge clock_i) begin
    if (!rstn_i)
      prdata_o <= `PSS_WORD_RESET;
    else if (setup && !pwrite_i)
      prdata_o <= next_rdata;
  end

  // The table and bank keep their documented zero reset.
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      for (i = 0; i < NUM_SEG; i = i + 1) begin
        ctrl_mem[i]  <= `PSS_WORD_RESET;
        pulse_mem[i] <= `PSS_WORD_RESET;
      end
      for (i = 0; i < BANK_SIZE; i = i + 1) begin
        bank_mem[i] <= `PSS_WORD_RESET;
      end
    end else if (wr_acc) begin
      if (is_ctrl)
        ctrl_mem[tab_n] <= pwdata_i;
      if (is_pulse)
        pulse_mem[tab_n] <= pwdata_i;
      if (in_bank)
        bank_mem[bank_n] <= pwdata_i;
    end
  end

  // ******************************************************************
  // Trigger pins
  // ******************************************************************
  // Three stages: two settle the pin, the third finds its rising edge. The
  // number pins share the first two stages so they line up with the edge.
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      idx_s1  <= 5'h00;
      idx_s2  <= 5'h00;
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
    end else begin
      idx_s1  <= segment_index_i;
      idx_s2  <= idx_s1;
      trig_s1 <= segment_trigger_input_i;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
    end
  end

  // The number pins must settle before the edge; both pass the same delay.
  wire       pin_trig = trig_s2 && !trig_s3;
  wire       sw_wr    = wr_acc && is_cmd;
  wire       sw_trig  = sw_wr && pwdata_i[`PSS_CMD_TRIG];
  wire       stop_req = sw_wr && pwdata_i[`PSS_CMD_STOP];
  wire       trig     = pin_trig || sw_trig;
  wire [4:0] trig_num = sw_trig ? pwdata_i[`PSS_CMD_NUM] : idx_s2;

  // ******************************************************************
  // Segment decode
  // ******************************************************************
  // Speed segments of type 0 never finish by themselves: they wait for the
  // next trigger, which is taken at once because nothing remains to run.
  wire [3:0] mode   = seg_ctrl[`PSS_F_MODE];
  wire [3:0] ttype  = seg_ctrl[`PSS_F_TYPE];
  wire       intr   = seg_ctrl[`PSS_F_INTR];
  wire       is_pos = (mode == `PSS_MODE_SINGLE) || (mode == `PSS_MODE_MULTI);
  wire       is_spd = (mode == `PSS_MODE_SPEED);
  wire       spd_go = is_spd && (ttype == `PSS_TYPE_INC);
  wire       hold   = is_spd && !spd_go && !nop_seg;
  wire       seg_done = nop_seg ? 1'b1 : is_pos ? motion_done_i :
                        spd_go ? speed_reached_i : 1'b1;
  wire       auto_next = !nop_seg && ((mode == `PSS_MODE_MULTI) || spd_go);
  wire       has_next  = (cur < NUM_SEG - 1);
  wire [4:0] jump_num  = seg_val[4:0];

  reg [31:0] next_target;
  reg        type_ok;
  always @* begin
    type_ok     = 1'b1;
    next_target = seg_val;
    case (ttype)
      `PSS_TYPE_ABS: next_target = seg_val;
      `PSS_TYPE_INC: next_target = cmd_target + seg_val;
      `PSS_TYPE_REL: next_target = feedback_position_i + seg_val;
      default:       type_ok     = 1'b0;
    endcase
    next_target = next_target + carry;
  end

  assign busy_o           = (state != S_IDLE);
  assign segment_number_o = cur + 5'd1;

  // ******************************************************************
  // Sequencer
  // ******************************************************************
  // Segment number n selects table entry n-1; number 0 is ignored here.
  // A trigger that arrives while a segment is being set up is held in a
  // single pending slot; a later trigger overwrites it, so the newest wins.
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      state             <= S_IDLE;
      cur               <= 5'h00;
      seg_ctrl          <= `PSS_WORD_RESET;
      seg_val           <= `PSS_WORD_RESET;
      nop_seg           <= 1'b0;
      pend              <= 1'b0;
      pend_num          <= 5'h00;
      carry             <= `PSS_WORD_RESET;
      cmd_target        <= `PSS_WORD_RESET;
      plan_strobe_o     <= 1'b0;
      run_mode_o        <= 2'd0;
      overlap_o         <= 1'b0;
      target_position_o <= `PSS_WORD_RESET;
      speed_value_o     <= `PSS_WORD_RESET;
      accel_time_o      <= `PSS_WORD_RESET;
      decel_time_o      <= `PSS_WORD_RESET;
      delay_time_o      <= `PSS_WORD_RESET;
      stop_o            <= 1'b0;
    end else begin
      plan_strobe_o <= 1'b0;
      stop_o        <= 1'b0;
      if (stop_req) begin
        state  <= S_IDLE;
        pend   <= 1'b0;
        carry  <= `PSS_WORD_RESET;
        stop_o <= 1'b1;
      end else begin
        case (state)
          S_IDLE: begin
            if (trig && trig_num != 5'h00) begin
              cur   <= trig_num - 5'd1;
              state <= S_FETCH;
            end
          end
          S_FETCH: begin
            seg_ctrl <= ctrl_mem[cur];
            seg_val  <= pulse_mem[cur];
            state    <= S_DECODE;
            if (trig && trig_num != 5'h00) begin
              pend     <= 1'b1;
              pend_num <= trig_num;
            end
          end
          S_DECODE: begin
            if (trig && trig_num != 5'h00) begin
              pend     <= 1'b1;
              pend_num <= trig_num;
            end
            nop_seg <= 1'b0;
            state   <= S_RUN;
            case (mode)
              `PSS_MODE_SINGLE, `PSS_MODE_MULTI: begin
                if (type_ok) begin
                  target_position_o <= next_target;
                  cmd_target        <= next_target;
                  speed_value_o     <= bank_mem[{`PSS_SPD_GRP, seg_ctrl[`PSS_F_SPD]}];
                  plan_strobe_o     <= 1'b1;
                end else begin
                  nop_seg <= 1'b1;
                end
                carry <= `PSS_WORD_RESET;
              end
              `PSS_MODE_SPEED: begin
                speed_value_o <= seg_val;
                plan_strobe_o <= 1'b1;
                carry         <= `PSS_WORD_RESET;
              end
              `PSS_MODE_JUMP: begin
                if (jump_num != 5'h00) begin
                  cur   <= jump_num - 5'd1;
                  state <= S_FETCH;
                end else begin
                  nop_seg <= 1'b1;
                end
              end
              default: nop_seg <= 1'b1;
            endcase
            run_mode_o   <= mode[1:0];
            overlap_o    <= seg_ctrl[`PSS_F_OVLP];
            accel_time_o <= bank_mem[{2'b00, seg_ctrl[`PSS_F_ACC]}];
            decel_time_o <= bank_mem[{2'b00, seg_ctrl[`PSS_F_DEC]}];
            delay_time_o <= bank_mem[{`PSS_DLY_GRP, seg_ctrl[`PSS_F_DLY]}];
          end
          S_RUN: begin
            // The interrupt bit is only judged here, once the segment is set.
            if (trig && trig_num != 5'h00 && intr && !nop_seg) begin
              carry <= is_pos ? remainder_i : `PSS_WORD_RESET;
              pend  <= 1'b0;
              cur   <= trig_num - 5'd1;
              state <= S_FETCH;
            end else if (seg_done && (pend || (trig && trig_num != 5'h00))) begin
              pend  <= 1'b0;
              // A trigger in this very cycle is newer than the pending one.
              cur   <= (trig && trig_num != 5'h00) ? trig_num - 5'd1 : pend_num - 5'd1;
              state <= S_FETCH;
            end else if (seg_done && auto_next) begin
              if (has_next) begin
                cur   <= cur + 5'd1;
                state <= S_FETCH;
              end else begin
                state <= S_IDLE;
              end
            end else if (seg_done && !hold) begin
              state <= S_IDLE;
            end else if (trig && trig_num != 5'h00) begin
              pend     <= 1'b1;
              pend_num <= trig_num;
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

endmodule // pss_sequencer

// ===== pss_seq_monitor.sv
/*
 Checker for the position segment sequencer ports.
 Assumes one clock domain and a bind from the testbench top file.
*/
`timescale 1ns/1ps
`include "pss_defs.vh"
module pss_seq_monitor (
  input wire        clock_i,            // system clock
  input wire        rstn_i,             // synchronous reset
  input wire        psel_i,             // APB select
  input wire        penable_i,          // APB enable
  input wire        pwrite_i,           // APB direction
  input wire [13:0] paddr_i,            // APB byte address
  input wire [31:0] pwdata_i,           // APB write data
  input wire        pready_o,           // APB ready
  input wire        pslverr_o,          // APB error
  input wire        plan_strobe_o,      // plan pulse
  input wire [31:0] target_position_o,  // planned target
  input wire        stop_o,             // stop pulse
  input wire        busy_o,             // sequence active
  input wire [4:0]  segment_number_o    // current segment
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  wire acc = psel_i && penable_i;
  wire cmd = acc && pwrite_i && paddr_i == {`PSS_CMD_REG, 2'b00};
  a_ready_high: assert property (acc |-> pready_o) else $error("ready low");
  a_ctrl_mapped: assert property (
    acc && paddr_i == 14'h2010 |-> !pslverr_o) else $error("ctrl slot refused");
  a_value_mapped: assert property (
    acc && paddr_i == 14'h21f8 |-> !pslverr_o) else $error("value slot refused");
  a_gap_unmapped: assert property (
    acc && paddr_i == 14'h21fc |-> pslverr_o) else $error("gap accepted");
  a_start_busy: assert property (
    cmd && pwdata_i[8] && !pwdata_i[9] && pwdata_i[4:0] != 5'h00 && !busy_o |-> ##[1:2] busy_o)
    else $error("trigger ignored");
  a_plan_in_run: assert property (
    plan_strobe_o |-> busy_o ##1 !plan_strobe_o) else $error("bad plan pulse");
  a_hold_target: assert property (
    !plan_strobe_o && $past(rstn_i) |-> $stable(target_position_o))
    else $error("target moved without plan");
  a_num_range: assert property (
    segment_number_o != 5'h00) else $error("segment number zero");
  a_stop_seen: assert property (
    cmd && pwdata_i[9] && busy_o |-> ##[1:3] stop_o) else $error("stop missing");
endmodule // pss_seq_monitor

// ===== pss_planner_model.sv
/*
 Trajectory planner model facing the sequencer.
 Assumes the same clock; lag_i of 0 keeps a segment running forever.
*/
`timescale 1ns/1ps
module pss_planner_model #(
  parameter REM = 32'h00000010
) (
  input  wire        clock_i,   // system clock
  input  wire        rstn_i,    // synchronous reset
  input  wire        strobe_i,  // new segment planned
  input  wire [1:0]  mode_i,    // mode of that segment
  input  wire [7:0]  lag_i,     // cycles to finish
  output reg         done_o,    // position finished pulse
  output reg         reach_o,   // speed reached pulse
  output wire [31:0] rem_o      // distance still to go
);
  // ****************************************
  // Motion timing
  // ****************************************
  reg act;
  reg spd;
  int cnt;
  // Pulses, not levels, so a stale finish never ends the next segment.
  always @(posedge clock_i) begin
    done_o <= 1'b0;
    reach_o <= 1'b0;
    if (!rstn_i) begin
      act <= 1'b0;
      cnt <= 0;
    end else if (strobe_i) begin
      act <= 1'b1;
      spd <= (mode_i == 2'h2);
      cnt <= 0;
    end else if (act) begin
      cnt <= cnt + 1;
      if (lag_i != 8'h00 && cnt + 1 >= lag_i) begin
        act <= 1'b0;
        done_o <= !spd;
        reach_o <= spd;
      end
    end
  end
  assign rem_o = act ? REM : 32'h00000000;
endmodule // pss_planner_model

// ===== test_position_segment_sequencer.sv
/*
 Self-checking bench of the position segment sequencer.
 Assumes the planner model and the bound checker.
*/
`timescale 1ns/1ps
`include "pss_defs.vh"
module test_position_segment_sequencer;
  // ****************************************
  // Stimulus and checks
  // ****************************************
  logic clock_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, er;
  logic segment_trigger_input_i = 0;
  logic [13:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, feedback_position_i = 32'h000003e8, rd;
  logic [4:0]  segment_index_i = 0;
  logic [7:0]  lag_i = 0;
  wire [31:0] prdata_o, target_position_o, speed_value_o, accel_time_o, decel_time_o;
  wire [31:0] delay_time_o, remainder_i;
  wire pready_o, pslverr_o, plan_strobe_o, overlap_o, stop_o, busy_o;
  wire motion_done_i, speed_reached_i;
  wire [1:0] run_mode_o;
  wire [4:0] segment_number_o;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  pss_sequencer uut (.clock_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .segment_index_i,
    .segment_trigger_input_i, .feedback_position_i, .motion_done_i, .speed_reached_i,
    .remainder_i, .plan_strobe_o, .run_mode_o, .overlap_o, .target_position_o,
    .speed_value_o, .accel_time_o, .decel_time_o, .delay_time_o, .stop_o, .busy_o,
    .segment_number_o);
  pss_planner_model pm (.clock_i, .rstn_i, .strobe_i(plan_strobe_o), .mode_i(run_mode_o),
    .lag_i, .done_o(motion_done_i), .reach_o(speed_reached_i), .rem_o(remainder_i));
  always #2.5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up;
    end
  end
  task chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] i, input logic [31:0] d);
    @(posedge clock_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, i, 2'b00, d};
    @(posedge clock_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clock_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
  endtask
  task seg(input int k, input logic [31:0] c, v);
    apb(1, 12'(`PSS_CTRL_BASE + 4 * (k - 1)), c);
    apb(1, 12'(`PSS_PULSE_BASE + 4 * (k - 1)), v);
  endtask
  task go(input logic [4:0] k);
    apb(1, `PSS_CMD_REG, {23'h0, 1'b1, 3'h0, k});
  endtask
  task wplan;
    int k;
    k = 0;
    do begin
      @(posedge clock_i);
      k++;
    end while (!(plan_strobe_o === 1'b1 && run_mode_o !== 2'h3) && k < 300);
    chk("planned", 1, plan_strobe_o);
  endtask
  task idle;
    int k;
    k = 0;
    while (busy_o !== 1'b0 && k < 300) begin
      @(posedge clock_i);
      k++;
    end
    chk("busy", 0, busy_o);
  endtask
  task quiet(input int n);
    repeat (n) @(posedge clock_i) chk("extra plan", 0, plan_strobe_o);
  endtask
  task t_regs;
    apb(0, `PSS_CTRL_BASE, 0); chk("ctrl reset", 0, rd);
    apb(0, `PSS_STAT_REG, 0); chk("status", 32'h00000401, rd);
    apb(1, `PSS_TABLE_LAST, 32'h80000001);
    apb(0, `PSS_TABLE_LAST, 0); chk("last value", 32'h80000001, rd);
    apb(0, `PSS_TABLE_LAST + 12'h1, 0); chk("gap err", 1, er);
    chk("gap data", 0, rd);
    $display("t_regs done");
  endtask
  task t_single;
    apb(1, `PSS_BANK_FIRST + 12'h1, 11); apb(1, `PSS_BANK_FIRST + 12'h2, 22);
    apb(1, `PSS_BANK_FIRST + 12'hb, 33); apb(1, `PSS_BANK_FIRST + 12'h14, 44);
    seg(1, 32'h43210000, 100); lag_i <= 8'h04; go(1);
    wplan; chk("target", 100, target_position_o);
    chk("accel", 11, accel_time_o); chk("decel", 22, decel_time_o);
    chk("speed", 33, speed_value_o); chk("delay", 44, delay_time_o);
    chk("mode", 0, run_mode_o);
    idle; quiet(10);
    $display("t_single done");
  endtask
  task t_multi;
    seg(2, 32'h00000011, 5); seg(3, 32'h00000020, 7);
    segment_index_i <= 5'h02; repeat (3) @(posedge clock_i);
    segment_trigger_input_i <= 1'b1;
    wplan; chk("target", 105, target_position_o);
    chk("mode", 1, run_mode_o);
    segment_trigger_input_i <= 1'b0;
    wplan; chk("target", 1007, target_position_o);
    idle; $display("t_multi done");
  endtask
  task t_jump_speed;
    seg(4, 32'h00000003, 1); go(4);
    wplan; chk("target", 100, target_position_o);
    idle; seg(5, 32'h00000012, 500); seg(6, 0, 42); go(5);
    wplan; chk("speed", 500, speed_value_o);
    chk("mode", 2, run_mode_o);
    wplan; chk("target", 42, target_position_o);
    idle; seg(10, 32'h00000002, 300); go(10);
    wplan; chk("speed", 300, speed_value_o);
    quiet(6); chk("held", 1, busy_o);
    go(1); wplan; chk("target", 100, target_position_o);
    idle; $display("t_jump_speed done");
  endtask
  task t_intr;
    lag_i <= 8'h00; seg(7, 32'h00001100, 1000); seg(8, 0, 200); go(7);
    wplan; chk("target", 1000, target_position_o);
    chk("overlap", 1, overlap_o);
    go(1); wplan; chk("target", 116, target_position_o);
    chk("overlap", 0, overlap_o);
    go(8); quiet(10);
    apb(0, `PSS_STAT_REG, 0); chk("status", 32'h00000301, rd);
    lag_i <= 8'h01;
    wplan; chk("target", 200, target_position_o);
    idle; seg(9, 32'h00000005, 0); go(9); quiet(8); idle;
    lag_i <= 8'h00; go(7); wplan;
    apb(1, `PSS_CMD_REG, 32'h00000200);
    er = 1'b1;
    repeat (4) @(posedge clock_i) if (stop_o === 1'b1) er = 1'b0;
    chk("stop seen", 0, er); idle;
    $display("t_intr done");
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clock_i);
    rstn_i <= 1'b1;
    t_regs; t_single; t_multi; t_jump_speed; t_intr;
    wrap_up;
  end
endmodule // test_position_segment_sequencer
bind pss_sequencer pss_seq_monitor mon (.clock_i, .rstn_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .plan_strobe_o, .target_position_o,
  .stop_o, .busy_o, .segment_number_o);
